// file: rtl/cpu_alu_core.sv
// cpu arithmetic datapath: status and control words, alu, multiplier, divider, shifter
`timescale 1ns/10ps

module cpu_alu_core
	import cpu_alu_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core sequencing
	input wire logic repeatRunning,
	input wire logic trapEntry,
	input wire logic divideHold,
	// status to the rest of the core
	output logic [3:0] cpuPriority,
	output logic userIrqOff,
	output logic programWindowOn,
	output logic engineBusy
);

	// ==========================================
	// decoding helpers
	function automatic logic isWregAddr(input logic [7:0] a);
		isWregAddr = (a[7:6] == WREG_PAGE) && (a[1:0] == 2'h0);
	endfunction : isWregAddr

	function automatic logic msbOf(input logic [15:0] v, input logic byteMode);
		msbOf = byteMode ? v[7] : v[15];
	endfunction : msbOf

	function automatic logic isDivide(input logic [4:0] op);
		isDivide = (op[4:2] == 3'h4);
	endfunction : isDivide

	// ==========================================
	// state
	logic [15:0] wreg [16];
	logic [15:0] memOperand;
	logic [15:0] memResult;
	logic [CMD_W-1:0] cmd;
	engine_state_t state;
	engine_state_t next_state;
	logic cFlag, zFlag, ovFlag, nFlag, dcFlag, raFlag;
	logic [3:0] priorityLevel;
	logic nestDisable;
	logic [3:0] divCount;
	logic [16:0] divRem;
	logic [15:0] divQuo;
	logic [15:0] divDvs;
	logic negQ, negR, divOv;

	// ==========================================
	// apb decode
	logic setupDone, writeEdge, engineIdle, addrHit;
	logic [31:0] readWord;
	logic [15:0] statusWord, controlWord, intctlWord;

	assign setupDone = psel & penable & ~pready;
	assign writeEdge = psel & penable & pready & pwrite;
	assign engineIdle = (state == ENG_IDLE);

	// register images, unimplemented bits read zero
	always_comb begin
		statusWord = 16'h0000;
		statusWord[ST_C] = cFlag;
		statusWord[ST_Z] = zFlag;
		statusWord[ST_OV] = ovFlag;
		statusWord[ST_N] = nFlag;
		statusWord[ST_RA] = raFlag;
		statusWord[ST_IPL +: 3] = priorityLevel[2:0];
		statusWord[ST_DC] = dcFlag;
		controlWord = 16'h0000;
		controlWord[CC_EXT] = priorityLevel[3];
		controlWord[CC_PSV] = programWindowOn;
		intctlWord = 16'h0000;
		intctlWord[IC_NEST] = nestDisable;
	end

	// read mux and address check
	always_comb begin
		readWord = 32'h0000_0000;
		addrHit = 1'b1;
		if (isWregAddr(paddr)) begin
			readWord = {16'h0000, wreg[paddr[5:2]]};
		end else begin
			case (paddr)
				OFF_STATUS: readWord = {16'h0000, statusWord};
				OFF_CONTROL: readWord = {16'h0000, controlWord};
				OFF_INTCTL: readWord = {16'h0000, intctlWord};
				OFF_MEM_IN: readWord = {16'h0000, memOperand};
				OFF_COMMAND: readWord = {7'h00, cmd};
				OFF_MEM_OUT: readWord = {16'h0000, memResult};
				OFF_ENGINE: readWord = {31'h0, ~engineIdle};
				default: addrHit = 1'b0;
			endcase
		end
	end

	// one wait state, answer registered
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setupDone;
			pslverr <= setupDone & ~addrHit;
			if (setupDone) begin
				prdata <= pwrite ? 32'h0000_0000 : readWord;
			end
		end
	end

	// ==========================================
	// operand selection and single-cycle alu
	logic [4:0] op;
	logic byteMode, srcMem, dstMem;
	logic [3:0] ra, rb, rd, lowPair, highPair;
	logic [4:0] lit;
	logic [15:0] opA, opB, bOp, aluRes;
	logic [16:0] sumW;
	logic [8:0] sumB;
	logic [4:0] sumNib;
	logic isSub, isArith, isShift, isMul, affNZ;
	logic [16:0] mulA, mulB;
	logic [33:0] product;

	assign op = cmd[CMD_OP +: 5];
	assign byteMode = cmd[CMD_BYTE];
	assign isShift = (op == OP_ASR) || (op == OP_LSR) || (op == OP_SL);
	assign srcMem = cmd[CMD_SRC_MEM] & ~isShift;
	assign dstMem = cmd[CMD_DST_MEM] & ~isShift;
	assign ra = cmd[CMD_RA +: 4];
	assign rb = cmd[CMD_RB +: 4];
	assign rd = cmd[CMD_RD +: 4];
	assign lit = cmd[CMD_LIT +: 5];
	assign lowPair = {ra[3:1], 1'b0};
	assign highPair = {ra[3:1], 1'b1};
	assign opA = srcMem ? memOperand : wreg[ra];
	assign opB = wreg[rb];
	assign isSub = (op == OP_SUB);
	assign isArith = (op == OP_ADD) || isSub;
	assign isMul = (op[4:3] == 2'h1);
	assign affNZ = (op <= OP_SL);

	// subtraction adds the inverted operand plus one, carry means no borrow
	assign bOp = isSub ? ~opB : opB;
	assign sumW = {1'b0, opA} + {1'b0, bOp} + {16'h0000, isSub};
	assign sumB = {1'b0, opA[7:0]} + {1'b0, bOp[7:0]} + {8'h00, isSub};
	assign sumNib = {1'b0, opA[3:0]} + {1'b0, bOp[3:0]} + {4'h0, isSub};

	// result of add, subtract, logic and shift
	always_comb begin
		case (op)
			OP_ADD, OP_SUB: aluRes = sumW[15:0];
			OP_AND: aluRes = opA & opB;
			OP_IOR: aluRes = opA | opB;
			OP_XOR: aluRes = opA ^ opB;
			OP_ASR: aluRes = 16'($signed(opA) >>> lit[3:0]);
			OP_LSR: aluRes = opA >> lit[3:0];
			OP_SL: aluRes = opA << lit[3:0];
			default: aluRes = 16'h0000;
		endcase
	end

	// 17x17 signed core, operands extended per mode
	always_comb begin
		case (op)
			OP_MUL_SS: begin
				mulA = {opA[15], opA};
				mulB = {opB[15], opB};
			end
			OP_MUL_SL: begin
				mulA = {opA[15], opA};
				mulB = {12'h000, lit};
			end
			OP_MUL_UL: begin
				mulA = {1'b0, opA};
				mulB = {12'h000, lit};
			end
			OP_MUL_US: begin
				mulA = {1'b0, opA};
				mulB = {opB[15], opB};
			end
			OP_MUL_BB: begin
				mulA = {9'h000, opA[7:0]};
				mulB = {9'h000, opB[7:0]};
			end
			default: begin
				mulA = {1'b0, opA};
				mulB = {1'b0, opB};
			end
		endcase
	end
	assign product = 34'($signed(mulA) * $signed(mulB));

	// ==========================================
	// divider operands
	logic divSigned, divWide;
	logic [31:0] dividend, dividendMag;
	logic [15:0] dvsMag;
	logic [16:0] divShift;
	logic [17:0] divDiff;

	assign divSigned = ~op[0];
	assign divWide = ~op[1];
	always_comb begin
		if (divWide) begin
			dividend = {wreg[highPair], wreg[lowPair]};
		end else begin
			dividend = {{16{divSigned & wreg[ra][15]}}, wreg[ra]};
		end
	end
	assign dividendMag = (divSigned & dividend[31]) ? 32'(-dividend) : dividend;
	assign dvsMag = (divSigned & wreg[rb][15]) ? 16'(-wreg[rb]) : wreg[rb];
	assign divShift = {divRem[15:0], divQuo[15]};
	assign divDiff = {1'b0, divShift} - {2'h0, divDvs};

	// ==========================================
	// engine sequencing
	always_comb begin
		next_state = state;
		case (state)
			ENG_IDLE: begin
				if (writeEdge && paddr == OFF_COMMAND) begin
					next_state = isDivide(pwdata[CMD_OP +: 5]) ? ENG_DIV_LOAD : ENG_EXEC;
				end
			end
			ENG_EXEC: next_state = ENG_IDLE;
			ENG_DIV_LOAD: next_state = divideHold ? ENG_DIV_LOAD : ENG_DIV_STEP;
			ENG_DIV_STEP: begin
				if (!divideHold && divCount == 4'(DIV_STEPS - 1)) begin
					next_state = ENG_DIV_FIX;
				end
			end
			ENG_DIV_FIX: next_state = divideHold ? ENG_DIV_FIX : ENG_DIV_WRITE;
			ENG_DIV_WRITE: next_state = divideHold ? ENG_DIV_WRITE : ENG_IDLE;
			default: next_state = ENG_IDLE;
		endcase
	end

	// state register and busy output
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= ENG_IDLE;
			engineBusy <= 1'b0;
		end else begin
			state <= next_state;
			engineBusy <= (next_state != ENG_IDLE);
		end
	end

	// command latch, ignored while the engine runs
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cmd <= '0;
		end else if (writeEdge && paddr == OFF_COMMAND && engineIdle) begin
			cmd <= pwdata[CMD_W-1:0];
		end
	end

	// iterative restoring divide on magnitudes, held while paused
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			divCount <= 4'h0;
			divRem <= 17'h00000;
			divQuo <= 16'h0000;
			divDvs <= 16'h0000;
			negQ <= 1'b0;
			negR <= 1'b0;
			divOv <= 1'b0;
		end else if (!divideHold) begin
			case (state)
				ENG_DIV_LOAD: begin
					divCount <= 4'h0;
					divRem <= {1'b0, dividendMag[31:16]};
					divQuo <= dividendMag[15:0];
					divDvs <= dvsMag;
					negQ <= divSigned & (dividend[31] ^ wreg[rb][15]);
					negR <= divSigned & dividend[31];
					divOv <= (dvsMag == 16'h0000) || (dividendMag[31:16] >= dvsMag);
				end
				ENG_DIV_STEP: begin
					divCount <= divCount + 4'h1;
					if (!divDiff[17]) begin
						divRem <= divDiff[16:0];
						divQuo <= {divQuo[14:0], 1'b1};
					end else begin
						divRem <= divShift;
						divQuo <= {divQuo[14:0], 1'b0};
					end
				end
				ENG_DIV_FIX: begin
					if (negQ) begin
						divQuo <= 16'(-divQuo);
					end
					if (negR) begin
						divRem <= {1'b0, 16'(-divRem[15:0])};
					end
				end
				default: divCount <= divCount;
			endcase
		end
	end

	// ==========================================
	// working registers and memory-side operands
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 16; i++) begin
				wreg[i] <= 16'h0000;
			end
			memOperand <= 16'h0000;
			memResult <= 16'h0000;
		end else begin
			if (writeEdge && engineIdle && isWregAddr(paddr)) begin
				wreg[paddr[5:2]] <= pwdata[15:0];
			end
			if (writeEdge && engineIdle && paddr == OFF_MEM_IN) begin
				memOperand <= pwdata[15:0];
			end
			if (state == ENG_EXEC && isMul) begin
				if (op == OP_MUL_BB) begin
					wreg[rd] <= product[15:0];
				end else begin
					wreg[{rd[3:1], 1'b0}] <= product[15:0];
					wreg[{rd[3:1], 1'b1}] <= product[31:16];
				end
			end else if (state == ENG_EXEC && affNZ) begin
				// byte results touch only the low byte
				if (dstMem) begin
					memResult <= byteMode ? {memResult[15:8], aluRes[7:0]} : aluRes;
				end else begin
					wreg[rd] <= byteMode ? {wreg[rd][15:8], aluRes[7:0]} : aluRes;
				end
			end
			if (state == ENG_DIV_WRITE && !divideHold) begin
				wreg[0] <= divQuo;
				wreg[1] <= divRem[15:0];
			end
		end
	end

	// ==========================================
	// condition flags, software writes only while idle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cFlag <= STATUS_RST[ST_C];
			zFlag <= STATUS_RST[ST_Z];
			ovFlag <= STATUS_RST[ST_OV];
			nFlag <= STATUS_RST[ST_N];
			dcFlag <= STATUS_RST[ST_DC];
		end else if (state == ENG_EXEC && affNZ) begin
			nFlag <= msbOf(aluRes, byteMode);
			if (byteMode ? (aluRes[7:0] != 8'h00) : (aluRes != 16'h0000)) begin
				zFlag <= 1'b0;
			end
			if (isArith) begin
				cFlag <= byteMode ? sumB[8] : sumW[16];
				dcFlag <= byteMode ? sumNib[4] : sumB[8];
				ovFlag <= (msbOf(opA, byteMode) == msbOf(bOp, byteMode))
					&& (msbOf(aluRes, byteMode) != msbOf(opA, byteMode));
			end
		end else if (state == ENG_DIV_WRITE && !divideHold) begin
			nFlag <= divQuo[15];
			ovFlag <= divOv;
			if (divQuo != 16'h0000) begin
				zFlag <= 1'b0;
			end
		end else if (writeEdge && engineIdle && paddr == OFF_STATUS) begin
			cFlag <= pwdata[ST_C];
			zFlag <= pwdata[ST_Z];
			ovFlag <= pwdata[ST_OV];
			nFlag <= pwdata[ST_N];
			dcFlag <= pwdata[ST_DC];
		end
	end

	// repeat loop indicator, read-only
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			raFlag <= STATUS_RST[ST_RA];
		end else begin
			raFlag <= repeatRunning;
		end
	end

	// ==========================================
	// priority level, program window and nesting control
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			priorityLevel <= PRIORITY_RST;
		end else begin
			if (trapEntry) begin
				priorityLevel[3] <= 1'b1; // trap entry wins over a clear
			end else if (writeEdge && paddr == OFF_CONTROL && !pwdata[CC_EXT]) begin
				priorityLevel[3] <= 1'b0;
			end
			if (writeEdge && paddr == OFF_STATUS && !nestDisable) begin
				priorityLevel[2:0] <= pwdata[ST_IPL +: 3];
			end
		end
	end
	assign cpuPriority = priorityLevel;

	// window enable and nesting disable
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			programWindowOn <= CONTROL_RST[CC_PSV];
			nestDisable <= INTCTL_RST[IC_NEST];
		end else begin
			if (writeEdge && paddr == OFF_CONTROL) begin
				programWindowOn <= pwdata[CC_PSV];
			end
			if (writeEdge && paddr == OFF_INTCTL) begin
				nestDisable <= pwdata[IC_NEST];
			end
		end
	end

	// user interrupts blocked at level 7 or with the extension bit
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			userIrqOff <= 1'b0;
		end else begin
			userIrqOff <= priorityLevel[3] | (priorityLevel[2:0] == 3'h7);
		end
	end

endmodule : cpu_alu_core

// file: rtl/cpu_alu_pkg.sv
// constants, field layouts and types shared by the cpu arithmetic datapath
package cpu_alu_pkg;

	// ==========================================
	// apb register offsets (byte addresses)
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h04;
	localparam logic [7:0] OFF_INTCTL = 8'h08;
	localparam logic [7:0] OFF_MEM_IN = 8'h0c;
	localparam logic [7:0] OFF_COMMAND = 8'h10;
	localparam logic [7:0] OFF_MEM_OUT = 8'h14;
	localparam logic [7:0] OFF_ENGINE = 8'h18;
	localparam logic [1:0] WREG_PAGE = 2'h1; // paddr[7:6] of working registers 0x40..0x7c

	// ==========================================
	// status word bit positions
	localparam int ST_C = 0;
	localparam int ST_Z = 1;
	localparam int ST_OV = 2;
	localparam int ST_N = 3;
	localparam int ST_RA = 4;
	localparam int ST_IPL = 5;
	localparam int ST_DC = 8;

	// control word and interrupt control bit positions
	localparam int CC_PSV = 2;
	localparam int CC_EXT = 3;
	localparam int IC_NEST = 15;

	// ==========================================
	// reset values
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] CONTROL_RST = 16'h0000;
	localparam logic [15:0] INTCTL_RST = 16'h0000;
	localparam logic [3:0] PRIORITY_RST = 4'h0;

	// ==========================================
	// command word fields
	localparam int CMD_OP = 0;   // [4:0]
	localparam int CMD_BYTE = 5;
	localparam int CMD_SRC_MEM = 6;
	localparam int CMD_DST_MEM = 7;
	localparam int CMD_RA = 8;   // [11:8]
	localparam int CMD_RB = 12;  // [15:12]
	localparam int CMD_RD = 16;  // [19:16]
	localparam int CMD_LIT = 20; // [24:20]
	localparam int CMD_W = 25;

	// operation codes
	localparam logic [4:0] OP_ADD = 5'h00;
	localparam logic [4:0] OP_SUB = 5'h01;
	localparam logic [4:0] OP_AND = 5'h02;
	localparam logic [4:0] OP_IOR = 5'h03;
	localparam logic [4:0] OP_XOR = 5'h04;
	localparam logic [4:0] OP_ASR = 5'h05;
	localparam logic [4:0] OP_LSR = 5'h06;
	localparam logic [4:0] OP_SL = 5'h07;
	localparam logic [4:0] OP_MUL_SS = 5'h08;
	localparam logic [4:0] OP_MUL_UU = 5'h09;
	localparam logic [4:0] OP_MUL_SL = 5'h0a;
	localparam logic [4:0] OP_MUL_UL = 5'h0b;
	localparam logic [4:0] OP_MUL_US = 5'h0c;
	localparam logic [4:0] OP_MUL_BB = 5'h0d;
	localparam logic [4:0] OP_DIV_S32 = 5'h10;
	localparam logic [4:0] OP_DIV_U32 = 5'h11;
	localparam logic [4:0] OP_DIV_S16 = 5'h12;
	localparam logic [4:0] OP_DIV_U16 = 5'h13;

	// ==========================================
	// divider timing: load, one step per divisor bit, sign fix, write back
	localparam int DIV_STEPS = 16;
	localparam int DIV_CYCLES = 19;

	// engine states
	typedef enum logic [2:0] {
		ENG_IDLE,
		ENG_EXEC,
		ENG_DIV_LOAD,
		ENG_DIV_STEP,
		ENG_DIV_FIX,
		ENG_DIV_WRITE
	} engine_state_t;

endpackage : cpu_alu_pkg

// file: testbench/cpu_alu_core_sva.sv
// assertion checker on the ports of the cpu arithmetic datapath
`timescale 1ns/10ps
module cpu_alu_core_sva
	import cpu_alu_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// core side
	input wire logic repeatRunning,
	input wire logic trapEntry,
	input wire logic divideHold,
	input wire logic [3:0] cpuPriority,
	input wire logic userIrqOff,
	input wire logic programWindowOn,
	input wire logic engineBusy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic wrEdge;
	logic nestOn;
	logic [4:0] busyLen;
	assign wrEdge = psel && penable && pready && pwrite;

	// ==========================================
	// helpers
	// copy of the nesting disable bit
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) nestOn <= 1'b0;
		else if (wrEdge && paddr == OFF_INTCTL) nestOn <= pwdata[IC_NEST];
	end
	// busy cycles not frozen by a hold
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) busyLen <= 5'h00;
		else if (!engineBusy) busyLen <= 5'h00;
		else if (!divideHold) busyLen <= busyLen + 5'h01;
	end

	// ==========================================
	// properties
	property p_ready_gap;
		psel && penable && !pready |=> pready;
	endproperty
	a_ready_gap: assert property (p_ready_gap) else $error("access phase not answered");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	property p_prio_write;
		wrEdge && paddr == OFF_STATUS && !nestOn |=> cpuPriority[2:0] == $past(pwdata[7:5]);
	endproperty
	a_prio_write: assert property (p_prio_write) else $error("priority bits not written");
	property p_prio_locked;
		wrEdge && paddr == OFF_STATUS && nestOn |=> $stable(cpuPriority[2:0]);
	endproperty
	a_prio_locked: assert property (p_prio_locked) else $error("locked priority changed");
	property p_ext_clear;
		wrEdge && paddr == OFF_CONTROL && !trapEntry |=> cpuPriority[3] == ($past(cpuPriority[3]) && $past(pwdata[CC_EXT]));
	endproperty
	a_ext_clear: assert property (p_ext_clear) else $error("extension bit write wrong");
	property p_ext_trap;
		trapEntry |=> cpuPriority[3];
	endproperty
	a_ext_trap: assert property (p_ext_trap) else $error("trap did not set extension");
	property p_irq_off;
		##1 userIrqOff == ($past(cpuPriority[3]) || $past(cpuPriority[2:0]) == 3'h7);
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("user interrupt block wrong");
	property p_window;
		wrEdge && paddr == OFF_CONTROL |=> programWindowOn == $past(pwdata[CC_PSV]);
	endproperty
	a_window: assert property (p_window) else $error("program window enable wrong");
	property p_busy_len;
		$fell(engineBusy) |-> busyLen == 5'd19 || busyLen == 5'd1;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("command length wrong");
	property p_busy_cap;
		busyLen <= 5'd19;
	endproperty
	a_busy_cap: assert property (p_busy_cap) else $error("divide runs too long");
	property p_err_zero;
		pslverr |-> prdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error answer data not zero");
	property p_repeat_read;
		pready && !pwrite && paddr == OFF_STATUS |-> prdata[ST_RA] == $past(repeatRunning, 2);
	endproperty
	a_repeat_read: assert property (p_repeat_read) else $error("repeat flag read wrong");
endmodule : cpu_alu_core_sva

bind cpu_alu_core cpu_alu_core_sva i_cpu_alu_core_sva (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.repeatRunning(repeatRunning), .trapEntry(trapEntry), .divideHold(divideHold), .cpuPriority(cpuPriority),
	.userIrqOff(userIrqOff), .programWindowOn(programWindowOn), .engineBusy(engineBusy));

// file: testbench/cpu_alu_core_test.sv
// self-checking bench for the cpu arithmetic datapath
`timescale 1ns/10ps
module cpu_alu_core_test
	import cpu_alu_pkg::*;
();
	logic mclk, reset, psel, penable, pwrite, pready, pslverr, errv;
	logic repeatRunning, trapEntry, divideHold, userIrqOff, programWindowOn, engineBusy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv, ex;
	logic [3:0] cpuPriority, ra;
	logic [4:0] op, lit;
	logic bm, mem, shift;
	logic [15:0] a, b, old, st, d, lo, hi, w1;
	int fails, checksDone, cycles, n, hold;
	logic [7:0] resetRegs [4] = '{OFF_STATUS, OFF_CONTROL, OFF_INTCTL, OFF_ENGINE};
	logic [4:0] ops [8] = '{OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_ASR, OP_LSR, OP_SL};
	logic [4:0] mops [6] = '{OP_MUL_SS, OP_MUL_UU, OP_MUL_SL, OP_MUL_UL, OP_MUL_US, OP_MUL_BB};

	cpu_alu_core i_cpu_alu_core (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.repeatRunning(repeatRunning), .trapEntry(trapEntry), .divideHold(divideHold), .cpuPriority(cpuPriority),
		.userIrqOff(userIrqOff), .programWindowOn(programWindowOn), .engineBusy(engineBusy));

	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ==========================================
	// checking and ending
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			stop_test();
		end
	end

	// ==========================================
	// apb master and command runner
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= dt;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		apb(1'b1, ad, dt);
	endtask : wr
	task automatic rd(input logic [7:0] ad);
		apb(1'b0, ad, 32'h0);
	endtask : rd
	function automatic logic [7:0] wa(input int k);
		return {WREG_PAGE, 4'(k), 2'b00};
	endfunction : wa
	// issue a command, count busy cycles, optional hold after five
	task automatic run(input logic [31:0] cmd);
		wr(OFF_COMMAND, cmd);
		n = 0;
		do begin
			@(posedge mclk);
			if (engineBusy === 1'b1) n++;
			divideHold <= (n >= 5 && n < 5 + hold);
		end while (engineBusy !== 1'b0 && n < 100);
	endtask : run

	// ==========================================
	// expected values
	function automatic logic [31:0] alu_exp(input logic [4:0] o, input logic y, input logic [15:0] x,
		input logic [15:0] z, input logic [15:0] ol, input logic [15:0] f, input logic [3:0] sh);
		logic [15:0] bb, r;
		logic [16:0] s;
		logic [8:0] s9;
		logic [4:0] s5;
		logic c0;
		int m;
		c0 = (o == OP_SUB);
		bb = c0 ? ~z : z;
		s = {1'b0, x} + {1'b0, bb} + 17'(c0);
		s9 = {1'b0, x[7:0]} + {1'b0, bb[7:0]} + 9'(c0);
		s5 = {1'b0, x[3:0]} + {1'b0, bb[3:0]} + 5'(c0);
		m = y ? 7 : 15;
		case (o)
			OP_AND: r = x & z;
			OP_IOR: r = x | z;
			OP_XOR: r = x ^ z;
			OP_ASR: r = $signed(x) >>> sh;
			OP_LSR: r = x >> sh;
			OP_SL: r = x << sh;
			default: r = s[15:0];
		endcase
		if (o <= OP_SUB) begin
			f[ST_C] = y ? s9[8] : s[16];
			f[ST_DC] = y ? s5[4] : s9[8];
			f[ST_OV] = (x[m] == bb[m]) && (r[m] != x[m]);
		end
		f[ST_N] = r[m];
		if (y ? r[7:0] != 8'h00 : r != 16'h0000) f[ST_Z] = 1'b0;
		return {f, y ? {ol[15:8], r[7:0]} : r};
	endfunction : alu_exp
	function automatic logic [31:0] mul_exp(input logic [4:0] o, input logic [15:0] x, input logic [15:0] z,
		input logic [4:0] l);
		logic [31:0] p, q;
		p = (o == OP_MUL_SS || o == OP_MUL_SL) ? {{16{x[15]}}, x} : {16'h0000, x};
		q = (o == OP_MUL_SS || o == OP_MUL_US) ? {{16{z[15]}}, z} : {16'h0000, z};
		if (o == OP_MUL_SL || o == OP_MUL_UL) q = {27'h0, l};
		if (o == OP_MUL_BB) q = {24'h0, z[7:0]};
		if (o == OP_MUL_BB) p = {24'h0, x[7:0]};
		return p * q;
	endfunction : mul_exp
	// {remainder, quotient}
	function automatic logic [31:0] div_exp(input logic [4:0] o, input logic [15:0] h, input logic [15:0] l,
		input logic [15:0] v);
		longint nn, dd;
		if (o[1]) nn = o[0] ? longint'(l) : longint'($signed(l));
		else nn = o[0] ? longint'({h, l}) : longint'($signed({h, l}));
		dd = o[0] ? longint'(v) : longint'($signed(v));
		return {16'(nn % dd), 16'(nn / dd)};
	endfunction : div_exp

	// ==========================================
	// main sequence
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeatRunning = 1'b0;
		trapEntry = 1'b0;
		divideHold = 1'b0;
		hold = 0;
		void'($urandom(7));
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		// reset values and undecoded places
		foreach (resetRegs[j]) begin
			rd(resetRegs[j]);
			check("reset value", rdv, 32'h0);
		end
		rd(8'h1c);
		check("unmapped error", errv, 32'h1);
		rd(8'h02);
		check("misaligned error", errv, 32'h1);
		$display("test registers done");
		// control word, extension bit and trap
		wr(OFF_CONTROL, 32'hffff);
		rd(OFF_CONTROL);
		check("control", rdv, 32'h4);
		check("window", programWindowOn, 32'h1);
		trapEntry <= 1'b1;
		@(posedge mclk);
		trapEntry <= 1'b0;
		rd(OFF_CONTROL);
		check("control trap", rdv, 32'hc);
		check("priority trap", cpuPriority, 32'h8);
		check("irq off trap", userIrqOff, 32'h1);
		wr(OFF_CONTROL, 32'h0);
		rd(OFF_CONTROL);
		check("control clear", rdv, 32'h0);
		check("irq off clear", userIrqOff, 32'h0);
		// status word, nesting lock, repeat flag
		wr(OFF_STATUS, 32'hffff);
		rd(OFF_STATUS);
		check("status", rdv, 32'h01ef);
		check("priority", cpuPriority, 32'h7);
		check("irq off level", userIrqOff, 32'h1);
		wr(OFF_INTCTL, 32'h8000);
		wr(OFF_STATUS, 32'h0);
		rd(OFF_STATUS);
		check("status locked", rdv, 32'h00e0);
		wr(OFF_INTCTL, 32'h0);
		wr(OFF_STATUS, 32'h0);
		repeatRunning <= 1'b1;
		rd(OFF_STATUS);
		check("repeat on", rdv, 32'h10);
		repeatRunning <= 1'b0;
		rd(OFF_STATUS);
		check("repeat off", rdv, 32'h0);
		$display("test control and status done");
		// alu and shifter, corners first then random
		for (int i = 0; i < 48; i++) begin
			op = ops[i % 8];
			shift = op >= OP_ASR;
			mem = i[3];
			bm = !mem && !shift && i[4];
			a = i < 8 ? 16'h7fff : 16'($urandom);
			b = i < 8 ? 16'h8001 : 16'($urandom);
			lit = i < 8 ? 5'h0f : 5'($urandom);
			old = 16'($urandom);
			st = 16'($urandom) & 16'h010f;
			w1 = (mem && !shift) ? ~a : a;
			wr(wa(1), {16'h0, w1});
			wr(wa(2), {16'h0, b});
			wr(wa(3), {16'h0, old});
			wr(OFF_MEM_IN, {16'h0, ~w1});
			wr(OFF_STATUS, {16'h0, st});
			run({7'h0, lit, 4'd3, 4'd2, 4'd1, mem, mem, bm, op});
			check("alu busy", n, 32'h1);
			ex = alu_exp(op, bm, a, b, old, st, lit[3:0]);
			rd(wa(3));
			check("alu result", rdv, (mem && !shift) ? old : ex[15:0]);
			rd(OFF_MEM_OUT);
			if (mem && !shift) check("memory result", rdv, ex[15:0]);
			rd(OFF_STATUS);
			check("flags", rdv, ex[31:16]);
		end
		$display("test alu done");
		// every multiply mode, all-ones corner first
		for (int i = 0; i < 12; i++) begin
			op = mops[i % 6];
			a = i < 6 ? 16'hffff : 16'($urandom);
			b = i < 6 ? 16'hffff : 16'($urandom);
			lit = i < 6 ? 5'h1f : 5'($urandom);
			old = 16'($urandom);
			st = 16'($urandom) & 16'h010f;
			wr(wa(1), {16'h0, a});
			wr(wa(2), {16'h0, b});
			wr(wa(5), {16'h0, old});
			wr(OFF_STATUS, {16'h0, st});
			run({7'h0, lit, 4'd4, 4'd2, 4'd1, 3'h0, op});
			check("multiply busy", n, 32'h1);
			ex = mul_exp(op, a, b, lit);
			rd(wa(4));
			check("product low", rdv, ex[15:0]);
			rd(wa(5));
			check("product high", rdv, op == OP_MUL_BB ? old : ex[31:16]);
			rd(OFF_STATUS);
			check("multiply flags", rdv, st);
		end
		$display("test multiply done");
		// every divide mode, odd and even pair base, one held run
		for (int i = 0; i < 8; i++) begin
			op = OP_DIV_S32 + 5'(i % 4);
			d = (16'($urandom) & 16'h7fff) | 16'h0010;
			if (!op[0] && i[2]) d = -d;
			lo = 16'($urandom);
			hi = op[0] ? 16'($urandom) % d : {16{lo[15]}};
			ra = (i >= 4 && !op[1]) ? 4'd7 : 4'd6;
			hold = i == 5 ? 4 : 0;
			wr(wa(6), {16'h0, lo});
			wr(wa(7), {16'h0, hi});
			wr(wa(8 + i), {16'h0, d});
			run({16'h0, 4'(8 + i), ra, 3'h0, op});
			check("divide cycles", n, 32'(19 + hold));
			ex = div_exp(op, hi, lo, d);
			rd(wa(0));
			check("quotient", rdv, ex[15:0]);
			rd(wa(1));
			check("remainder", rdv, ex[31:16]);
		end
		$display("test divide done");
		stop_test();
	end
endmodule : cpu_alu_core_test
